// ---- verilog/psq_pkg.sv ----
package psq_pkg;
    // Clock and derived rates
    localparam int CLK_MHZ       = 200;
    localparam int US_PER_MS     = 1000;
    localparam int TICK_CYC_DEF  = US_PER_MS * CLK_MHZ;
    localparam int KILL_FILT_US  = 30;
    localparam int KILL_FILT_CYC = KILL_FILT_US * CLK_MHZ;
    // Timer lengths in milliseconds
    localparam int MS_W          = 18;
    localparam int EXT_W         = 16;
    localparam logic [MS_W-1:0] ON_DB_MS   = 18'h00080;
    localparam logic [MS_W-1:0] BLANK_MS   = 18'h00200;
    localparam logic [MS_W-1:0] OFF_DB_MS  = 18'h00020;
    localparam logic [MS_W-1:0] KILL_DLY_MS = 18'h00080;
    localparam logic [MS_W-1:0] LOCK_MS    = 18'h00100;
    localparam logic [MS_W-1:0] REL_DB_MS  = 18'h00020;

    typedef enum logic [3:0] {
        PSQ_OFF     = 4'h0,
        PSQ_ON_DB   = 4'h1,
        PSQ_BLANK   = 4'h3,
        PSQ_REL_ON  = 4'h2,
        PSQ_RUN     = 4'h6,
        PSQ_OFF_DB  = 4'h7,
        PSQ_IRQ     = 4'h5,
        PSQ_LOCK    = 4'h4,
        PSQ_REL_OFF = 4'hC
    } psq_state_t;
endpackage : psq_pkg

// ---- verilog/psq_tmr_if.sv ----
interface psq_tmr_if;
    import psq_pkg::*;
    logic            clear;
    logic [MS_W-1:0] limit;
    logic            done;
    modport ctl (output clear, output limit, input done);
    modport tmr (input clear, input limit, output done);
endinterface : psq_tmr_if

// ---- verilog/psq_timer.sv ----
module psq_timer
    import psq_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYC_DEF
)(
    input  wire logic clock,
    input  wire logic reset,
    psq_tmr_if.tmr    tif
);
    logic [31:0]     pre_q;
    logic [MS_W-1:0] ms_q;
    wire             tick = (pre_q == 32'(TICK_CYC - 1));
    wire             sat  = &ms_q;

    // Prescaler restarts with the timer so every interval is exact
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            pre_q <= 32'h0;
            ms_q  <= '0;
        end
        else if (tif.clear)
        begin
            pre_q <= 32'h0;
            ms_q  <= '0;
        end
        else
        begin
            pre_q <= tick ? 32'h0 : pre_q + 32'h1;
            if (tick && !sat)
                ms_q <= ms_q + 18'h1;
        end
    end

    assign tif.done = (ms_q >= tif.limit);
endmodule : psq_timer

// ---- verilog/psq_seq.sv ----
module psq_seq
    import psq_pkg::*;
#(
    parameter bit EN_ACTIVE_HIGH = 1'b1,
    parameter int TICK_CYC       = TICK_CYC_DEF,
    parameter int KILL_FILT      = KILL_FILT_CYC
)(
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             pushbutton_n,
    input  wire logic             kill_n,
    input  wire logic [EXT_W-1:0] off_time_ext,
    input  wire logic [EXT_W-1:0] kill_delay_ext,
    output logic                  power_enable,
    output logic                  irq_n
);
    psq_tmr_if  tif ();
    psq_state_t state_q, state_d;
    logic [15:0] kf_q;
    logic        kill_low_q, en_on_q, irq_q, tmr_restart;
    wire         pressed = !pushbutton_n;
    wire         done    = tif.done;

    psq_timer #(.TICK_CYC(TICK_CYC)) u_psq_timer (
        .clock (clock),
        .reset (reset),
        .tif   (tif)
    );

    // Filter counts consecutive low cycles; any high restarts it
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            kf_q       <= 16'h0;
            kill_low_q <= 1'b0;
        end
        else if (kill_n)
        begin
            kf_q       <= 16'h0;
            kill_low_q <= 1'b0;
        end
        else
        begin
            if (kf_q != 16'(KILL_FILT - 1))
                kf_q <= kf_q + 16'h1;
            kill_low_q <= (kf_q == 16'(KILL_FILT - 1));
        end
    end

    always_comb
    begin
        state_d     = state_q;
        tmr_restart = 1'b0;
        case (state_q)
            PSQ_OFF:
                if (pressed)
                    state_d = PSQ_ON_DB;
            PSQ_ON_DB:
                if (!pressed)
                    state_d = PSQ_OFF;
                else if (done)
                    state_d = PSQ_BLANK;
            PSQ_BLANK:
                // Inputs are not looked at until the timer ends
                if (done)
                    state_d = kill_low_q ? PSQ_REL_OFF : PSQ_REL_ON;
            PSQ_REL_ON:
                if (kill_low_q)
                    state_d = PSQ_LOCK;
                else if (pressed)
                    tmr_restart = 1'b1;
                else if (done)
                    state_d = PSQ_RUN;
            PSQ_RUN:
                if (kill_low_q)
                    state_d = PSQ_LOCK;
                else if (pressed)
                    state_d = PSQ_OFF_DB;
            PSQ_OFF_DB:
                if (kill_low_q)
                    state_d = PSQ_LOCK;
                else if (!pressed)
                    state_d = PSQ_RUN;
                else if (done)
                    state_d = PSQ_IRQ;
            PSQ_IRQ:
                if (kill_low_q)
                    state_d = PSQ_LOCK;
                else if (done)
                    state_d = PSQ_REL_OFF;
            PSQ_LOCK:
                if (done)
                    state_d = PSQ_REL_OFF;
            PSQ_REL_OFF:
                if (pressed)
                    tmr_restart = 1'b1;
                else if (done)
                    state_d = PSQ_OFF;
            default:
                state_d = PSQ_OFF;
        endcase
    end

    // Timer restarts on every state change
    assign tif.clear = tmr_restart || (state_d != state_q);

    always_comb
    begin
        case (state_q)
            PSQ_ON_DB:   tif.limit = ON_DB_MS;
            PSQ_BLANK:   tif.limit = BLANK_MS;
            PSQ_OFF_DB:  tif.limit = OFF_DB_MS + MS_W'(off_time_ext);
            PSQ_IRQ:     tif.limit = KILL_DLY_MS + MS_W'(kill_delay_ext);
            PSQ_LOCK:    tif.limit = LOCK_MS;
            PSQ_REL_ON,
            PSQ_REL_OFF: tif.limit = REL_DB_MS;
            default:     tif.limit = {MS_W{1'b1}};
        endcase
    end

    wire en_d  = (state_d == PSQ_BLANK) || (state_d == PSQ_REL_ON) || (state_d == PSQ_RUN)
              || (state_d == PSQ_OFF_DB) || (state_d == PSQ_IRQ);
    wire irq_d = (state_d == PSQ_IRQ);

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state_q <= PSQ_OFF;
            en_on_q <= 1'b0;
            irq_q   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            en_on_q <= en_d;
            irq_q   <= irq_d;
        end
    end

    // Polarity is a build choice; timing is shared by both variants
    assign power_enable = en_on_q ~^ EN_ACTIVE_HIGH;
    assign irq_n        = !irq_q;

    property p_abort;
        @(posedge clock) disable iff (reset)
        (state_q == PSQ_BLANK && done && kill_low_q) |=> !en_on_q && state_q == PSQ_REL_OFF;
    endproperty
    a_abort: assert property (p_abort) else $error("power-on not aborted");

    property p_kill_run;
        @(posedge clock) disable iff (reset)
        (state_q == PSQ_RUN && kill_low_q) |=> !en_on_q ##1 !en_on_q;
    endproperty
    a_kill_run: assert property (p_kill_run) else $error("kill did not drop enable");

    property p_lock;
        @(posedge clock) disable iff (reset)
        (state_q == PSQ_RUN && kill_low_q) |=> (state_q == PSQ_LOCK) [*8];
    endproperty
    a_lock: assert property (p_lock) else $error("lockout not held");

    property p_pol;
        @(posedge clock) disable iff (reset)
        (state_q == PSQ_RUN) |-> power_enable == EN_ACTIVE_HIGH;
    endproperty
    a_pol: assert property (p_pol) else $error("enable polarity wrong");

    property p_off_db;
        @(posedge clock) disable iff (reset)
        (state_q == PSQ_OFF_DB && !pressed && !kill_low_q) |=> state_q == PSQ_RUN && irq_n;
    endproperty
    a_off_db: assert property (p_off_db) else $error("turn-off debounce not restarted");

    property p_off_lim;
        @(posedge clock) disable iff (reset)
        (state_q == PSQ_OFF_DB) |-> tif.limit == OFF_DB_MS + MS_W'(off_time_ext);
    endproperty
    a_off_lim: assert property (p_off_lim) else $error("turn-off length wrong");

    property p_irq;
        @(posedge clock) disable iff (reset)
        (state_q == PSQ_IRQ && done && !kill_low_q) |=> !en_on_q && irq_n;
    endproperty
    a_irq: assert property (p_irq) else $error("kill delay did not release");

    property p_filt;
        @(posedge clock) disable iff (reset)
        kill_n |=> !kill_low_q;
    endproperty
    a_filt: assert property (p_filt) else $error("kill glitch accepted");

    property p_on;
        @(posedge clock) disable iff (reset)
        $rose(en_on_q) |-> $past(state_q) == PSQ_ON_DB && $past(done);
    endproperty
    a_on: assert property (p_on) else $error("enable without debounce");

    property p_blank;
        @(posedge clock) disable iff (reset)
        (state_q == PSQ_BLANK && !done) |=> state_q == PSQ_BLANK && en_on_q;
    endproperty
    a_blank: assert property (p_blank) else $error("blanking interrupted");

    property p_int;
        @(posedge clock) disable iff (reset)
        (state_q == PSQ_OFF_DB && pressed && done && !kill_low_q) |=> !irq_n && en_on_q;
    endproperty
    a_int: assert property (p_int) else $error("interrupt not raised");

    property p_rel;
        @(posedge clock) disable iff (reset)
        (state_q == PSQ_REL_OFF && pressed) |=> state_q == PSQ_REL_OFF;
    endproperty
    a_rel: assert property (p_rel) else $error("release not debounced");

    property p_idle;
        @(posedge clock) disable iff (reset)
        (state_q == PSQ_OFF) |-> !en_on_q && irq_n;
    endproperty
    a_idle: assert property (p_idle) else $error("off state outputs wrong");

    c_on:    cover property (@(posedge clock) disable iff (reset) state_q == PSQ_RUN);
    c_abort: cover property (@(posedge clock) disable iff (reset) state_q == PSQ_BLANK && done && kill_low_q);
    c_irq:   cover property (@(posedge clock) disable iff (reset) state_q == PSQ_IRQ && done);
    c_lock:  cover property (@(posedge clock) disable iff (reset) state_q == PSQ_LOCK && done);
endmodule : psq_seq

// ---- tb/psq_cpu_model.sv ----
module psq_cpu_model (
    input  wire logic        clock,
    input  wire logic        irq_n,
    input  wire logic        kill_cmd,
    input  wire logic        answer,
    input  wire logic [31:0] answer_dly,
    output logic             kill_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] cnt_q  = 32'h0;
    logic        kill_q = 1'b1;
    // Cycles since the interrupt fell
    always_ff @(posedge clock)
    begin
        cnt_q <= irq_n ? 32'h0 : cnt_q + 32'h1;
    end
    // Commanded low, or answer once the set delay has run
    always_ff @(posedge clock)
    begin
        kill_q <= !(kill_cmd || (answer && !irq_n && cnt_q >= answer_dly));
    end
    assign kill_n = kill_q;
endmodule : psq_cpu_model

// ---- tb/test_pushbutton_power_sequencer.sv ----
module test_pushbutton_power_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import psq_pkg::*;
    // Short tick keeps the run small
    localparam int T  = 10;
    localparam int KF = 4;
    logic             clock;
    logic             reset;
    logic             pushbutton_n;
    logic             kill_cmd;
    logic             answer;
    logic [31:0]      answer_dly;
    logic [EXT_W-1:0] off_ext;
    logic [EXT_W-1:0] kill_ext;
    logic             kill_n;
    logic             pe_hi;
    logic             pe_lo;
    logic             irq_hi;
    logic             irq_lo;
    int               err_count;
    int               n_compared;

    psq_seq #(.EN_ACTIVE_HIGH(1'b1), .TICK_CYC(T), .KILL_FILT(KF)) u_psq_seq (
        .clock(clock), .reset(reset), .pushbutton_n(pushbutton_n), .kill_n(kill_n),
        .off_time_ext(off_ext), .kill_delay_ext(kill_ext), .power_enable(pe_hi), .irq_n(irq_hi));
    psq_seq #(.EN_ACTIVE_HIGH(1'b0), .TICK_CYC(T), .KILL_FILT(KF)) u_psq_seq_lo (
        .clock(clock), .reset(reset), .pushbutton_n(pushbutton_n), .kill_n(kill_n),
        .off_time_ext(off_ext), .kill_delay_ext(kill_ext), .power_enable(pe_lo), .irq_n(irq_lo));
    psq_cpu_model u_psq_cpu_model (
        .clock(clock), .irq_n(irq_hi), .kill_cmd(kill_cmd), .answer(answer),
        .answer_dly(answer_dly), .kill_n(kill_n));

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic close_out;
        if (err_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    task automatic check_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check_bit

    // Tolerance covers register stages and, on kill paths, the KF-cycle kill filter
    task automatic check_span(input int n, input int lo, input int hi);
        n_compared++;
        if (n < lo || n > hi)
        begin
            err_count++;
            $display("wrong value at %0t: got %0h expected %0h", $time, n, lo);
        end
    endtask : check_span

    task automatic check_on(input logic want);
        check_bit(pe_hi, want);
        check_bit(pe_lo, !want);
    endtask : check_on

    task automatic check_irq(input logic want);
        check_bit(irq_hi, want);
        check_bit(irq_lo, want);
    endtask : check_irq

    task automatic ms(input int k);
        repeat (k * T) @(negedge clock);
    endtask : ms

    task automatic wait_sig(input bit sel, input logic want, input int bound, output int n);
        for (n = 1; n <= bound; n++)
        begin
            @(negedge clock);
            if ((sel ? irq_hi : pe_hi) === want)
                return;
        end
        err_count++;
        close_out();
    endtask : wait_sig

    task automatic power_on(input logic abort);
        int n;
        kill_cmd = 1'b1;
        pushbutton_n = 1'b0;
        ms(100);
        pushbutton_n = 1'b1;
        ms(1);
        check_on(1'b0);
        pushbutton_n = 1'b0;
        wait_sig(1'b0, 1'b1, 200 * T, n);
        check_span(n, 128 * T, 128 * T + 3);
        ms(300);
        kill_cmd = abort;
        ms(200);
        check_on(1'b1);
        if (abort)
        begin
            wait_sig(1'b0, 1'b0, 50 * T, n);
            check_span(n, 12 * T - 3, 12 * T + KF + 3);
        end
        else
            ms(20);
        pushbutton_n = 1'b1;
        ms(40);
        check_on(!abort);
    endtask : power_on

    task automatic kill_and_lockout;
        int n;
        kill_cmd = 1'b1;
        repeat (KF - 1) @(negedge clock);
        kill_cmd = 1'b0;
        ms(2);
        check_on(1'b1);
        kill_cmd = 1'b1;
        wait_sig(1'b0, 1'b0, 20, n);
        check_span(n, KF, KF + 4);
        check_irq(1'b1);
        kill_cmd = 1'b0;
        ms(5);
        pushbutton_n = 1'b0;
        ms(200);
        check_on(1'b0);
        pushbutton_n = 1'b1;
        // Press just after lockout lands in release debounce and is refused
        ms(60);
        pushbutton_n = 1'b0;
        ms(150);
        check_on(1'b0);
        pushbutton_n = 1'b1;
        ms(40);
    endtask : kill_and_lockout

    task automatic off_timeout;
        int n;
        off_ext = 16'h0002;
        kill_ext = 16'h0003;
        power_on(1'b0);
        pushbutton_n = 1'b0;
        ms(33);
        pushbutton_n = 1'b1;
        ms(1);
        check_irq(1'b1);
        pushbutton_n = 1'b0;
        wait_sig(1'b1, 1'b0, 50 * T, n);
        check_span(n, 34 * T, 34 * T + 3);
        check_on(1'b1);
        check_irq(1'b0);
        wait_sig(1'b0, 1'b0, 200 * T, n);
        check_span(n, 131 * T, 131 * T + 3);
        check_irq(1'b1);
        pushbutton_n = 1'b1;
        ms(40);
        off_ext = 16'h0000;
        kill_ext = 16'h0000;
    endtask : off_timeout

    task automatic off_answered;
        int n;
        answer = 1'b1;
        answer_dly = 5 * T;
        power_on(1'b0);
        pushbutton_n = 1'b0;
        wait_sig(1'b1, 1'b0, 50 * T, n);
        check_span(n, 32 * T, 32 * T + 3);
        wait_sig(1'b0, 1'b0, 20 * T, n);
        check_span(n, 5 * T, 5 * T + KF + 4);
        pushbutton_n = 1'b1;
        answer = 1'b0;
        ms(300);
    endtask : off_answered

    initial
    begin
        reset = 1'b1;
        pushbutton_n = 1'b1;
        kill_cmd = 1'b0;
        answer = 1'b0;
        answer_dly = 32'h0;
        off_ext = 16'h0000;
        kill_ext = 16'h0000;
        err_count = 0;
        n_compared = 0;
        repeat (5) @(negedge clock);
        reset = 1'b0;
        check_on(1'b0);
        check_irq(1'b1);
        power_on(1'b0);
        kill_and_lockout();
        off_timeout();
        off_answered();
        power_on(1'b1);
        close_out();
    end
endmodule : test_pushbutton_power_sequencer
